// File: hw/hcs_pkg.sv
/*
 Package for the terminal host control/status pin block: timing counts,
 event carrier structs and the host access decode enum.
 Assumes a 200 MHz core clock; no other dependencies.
*/
package hcs_pkg;

   localparam int CLK_PERIOD_PS     = 5000;
   localparam int STROBE_NS         = 500;
   localparam int STROBE_CYC        = (STROBE_NS * 1000) / CLK_PERIOD_PS;
   localparam int FAILSAFE_US       = 760;
   localparam int FAILSAFE_CYC      = (FAILSAFE_US * 1000000) / CLK_PERIOD_PS;
   localparam int LEAD_SHORT_NS     = 2700;
   localparam int LEAD_SHORT_CYC    = (LEAD_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LEAD_LONG_NS      = 5700;
   localparam int LEAD_LONG_CYC     = (LEAD_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DATA_W            = 16;
   localparam int CTRL_LEAD_BIT     = 12;
   localparam logic [15:0] CTRL_RESET  = 16'h0000;

   typedef enum logic [1:0] {
      HCS_ACC_NONE,
      HCS_ACC_REG,
      HCS_ACC_RAM
   } hcs_acc_e;

   // Command word events from the bus decoder
   typedef struct packed {
      logic cmd_word;     // A command word arrived (valid or not)
      logic cmd_valid;    // It was valid and addressed to us
      logic broadcast;
      logic transmit;
      logic rt_to_rt;
   } hcs_cmd_s;

   // Message progress events from the terminal sequencer
   typedef struct packed {
      logic seq_error;
      logic msg_done;     // Message received correctly, status about to go out
      logic msg_end;      // Message fully processed
      logic ram_need;     // Sequencer will need RAM after the lead time
      logic ram_last;     // Final RAM access of the command completes
   } hcs_seq_s;

endpackage : hcs_pkg

// File: hw/hcs_pulse.sv
/*
 Retriggerable low-going pulse timer with early abort.
 Assumes synchronous start/abort inputs on the core clock.
*/
`timescale 1ns/1ps
module hcs_pulse #(
   parameter int LEN = 100
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic start,
   input  wire logic abort,
   output logic      pulse_n
);
   localparam int CW = $clog2(LEN + 1);
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q   <= '0;
         pulse_n <= 1'b1;
      end else if (abort) begin
         cnt_q   <= '0;
         pulse_n <= 1'b1;
      end else if (start) begin
         cnt_q   <= CW'(LEN - 1);
         pulse_n <= 1'b0;
      end else if (cnt_q != '0) begin
         cnt_q   <= cnt_q - 1'b1;
      end else begin
         pulse_n <= 1'b1;
      end
   end
endmodule : hcs_pulse

// File: hw/hcs_lead.sv
/*
 RAM busy lead timer: once a RAM need is announced, counts the selected
 lead time and then reports the RAM as granted to the sequencer.
 Assumes lead counts given in core clock cycles.
*/
`timescale 1ns/1ps
module hcs_lead #(
   parameter int SHORT_CYC = 540,
   parameter int LONG_CYC  = 1140
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic need,
   input  wire logic long_sel,
   input  wire logic release_ram,
   output logic      busy,
   output logic      granted
);
   localparam int CW = $clog2(LONG_CYC + 1);
   logic [CW-1:0] cnt_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q   <= '0;
         busy    <= 1'b0;
         granted <= 1'b0;
      end else if (release_ram) begin
         cnt_q   <= '0;
         busy    <= 1'b0;
         granted <= 1'b0;
      end else if (need && !busy) begin
         busy    <= 1'b1;
         // Load one short so the grant lands exactly the lead time after busy
         cnt_q   <= long_sel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
      end else if (busy && cnt_q != '0) begin
         cnt_q   <= cnt_q - 1'b1;
      end else if (busy) begin
         granted <= 1'b1;
      end
   end
endmodule : hcs_lead

// File: hw/hcs_top.sv
/*
 Host control inputs and status outputs of a serial-bus remote terminal.
 Assumes host pins already synchronous to CLK; decoder and sequencer
 events arrive as one-cycle pulses in the package structs.
*/
`timescale 1ns/1ps
module hcs_top #(
   parameter int FAILSAFE_CYC = hcs_pkg::FAILSAFE_CYC
) (
   input  wire logic                          CLK,
   input  wire logic                          RST_B,
   input  wire logic                          CHIP_SELECT_N,
   input  wire logic                          READ_WRITE,
   input  wire logic                          REG_ACCESS_N,
   input  wire logic                          OUTPUT_ENABLE_N,
   input  wire logic                          ILLEGAL_COMMAND_FLAG,
   input  wire logic [hcs_pkg::DATA_W-1:0]    DATA_IN,
   output logic      [hcs_pkg::DATA_W-1:0]    DATA_OUT,
   output logic                               DATA_OE,
   input  wire logic [hcs_pkg::DATA_W-1:0]    RAM_RDATA,
   output logic                               RAM_HOST_WE,
   output logic                               RAM_HOST_RE,
   input  wire hcs_pkg::hcs_cmd_s             CMD_EVT,
   input  wire hcs_pkg::hcs_seq_s             SEQ_EVT,
   output logic                               RAM_GRANT,
   input  wire logic                          TX_WORD_VALID,
   input  wire logic [hcs_pkg::DATA_W-1:0]    TX_WORD,
   input  wire logic                          LOOP_WORD_VALID,
   input  wire logic [hcs_pkg::DATA_W-1:0]    LOOP_WORD,
   output logic      [hcs_pkg::DATA_W-1:0]    CONTROL_REG,
   output logic                               CMD_ILLEGAL,
   output logic                               MESSAGE_ERROR_OUT,
   output logic                               LOOPBACK_ERROR_OUT,
   output logic                               FAILSAFE_TIMER_N,
   output logic                               COMMAND_STROBE_N,
   output logic                               TERMINAL_ACTIVE_N,
   output logic                               BROADCAST_N,
   output logic                               TRANSMIT_RECEIVE,
   output logic                               TERMINAL_TO_TERMINAL,
   output logic                               VALID_MESSAGE,
   output logic                               RAM_BUSY
);

   function automatic hcs_pkg::hcs_acc_e decode_access(input logic cs_n, input logic reg_n);
      if (cs_n)
         return hcs_pkg::HCS_ACC_NONE;
      else if (!reg_n)
         return hcs_pkg::HCS_ACC_REG;
      else
         return hcs_pkg::HCS_ACC_RAM;
   endfunction : decode_access

   hcs_pkg::hcs_acc_e acc;
   logic [hcs_pkg::DATA_W-1:0] tx_hold_q;
   logic            tx_pend_q;
   logic            message_error_out_q;
   logic            illegal_q;
   logic            valid_cmd;
   logic            strobe_n;
   logic            strobe_fall;
   logic            strobe_prev_q;
   logic            fs_n;
   logic            lead_busy;
   logic            lead_grant;
   logic            active_q;
   logic            valid_message_rise;

   assign acc = decode_access(CHIP_SELECT_N, REG_ACCESS_N);

   // Host-flagged illegal command turns a decoded valid command into an error
   assign valid_cmd = CMD_EVT.cmd_valid && !ILLEGAL_COMMAND_FLAG;

   // Control register write and status read path
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CONTROL_REG <= hcs_pkg::CTRL_RESET;
      end else if (acc == hcs_pkg::HCS_ACC_REG && !READ_WRITE) begin
         CONTROL_REG <= DATA_IN;
      end
   end

   // Status word: low bits hold the status flags, active high, for the host
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         DATA_OUT <= '0;
         DATA_OE  <= 1'b0;
      end else begin
         DATA_OE <= !OUTPUT_ENABLE_N && acc != hcs_pkg::HCS_ACC_NONE && READ_WRITE;
         case (acc)
            hcs_pkg::HCS_ACC_REG: begin
               DATA_OUT <= {8'h00, RAM_BUSY, VALID_MESSAGE, TERMINAL_TO_TERMINAL,
                            TRANSMIT_RECEIVE, !BROADCAST_N, !TERMINAL_ACTIVE_N,
                            LOOPBACK_ERROR_OUT, message_error_out_q};
            end
            hcs_pkg::HCS_ACC_RAM: begin
               DATA_OUT <= RAM_RDATA;
            end
            default: begin
               DATA_OUT <= DATA_OUT;
            end
         endcase
      end
   end

   // Host RAM strobes; the host itself keeps clear of a busy RAM
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         RAM_HOST_WE <= 1'b0;
         RAM_HOST_RE <= 1'b0;
      end else begin
         RAM_HOST_WE <= acc == hcs_pkg::HCS_ACC_RAM && !READ_WRITE;
         RAM_HOST_RE <= acc == hcs_pkg::HCS_ACC_RAM && READ_WRITE;
      end
   end

   // Message error: set on illegal or sequence error, cleared by valid command
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         message_error_out_q    <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= CMD_EVT.cmd_valid && ILLEGAL_COMMAND_FLAG;
         if ((CMD_EVT.cmd_valid && ILLEGAL_COMMAND_FLAG) || SEQ_EVT.seq_error)
            message_error_out_q <= 1'b1;
         else if (valid_cmd)
            message_error_out_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         MESSAGE_ERROR_OUT <= 1'b0;
         CMD_ILLEGAL       <= 1'b0;
      end else begin
         MESSAGE_ERROR_OUT <= message_error_out_q;
         CMD_ILLEGAL       <= illegal_q;
      end
   end

   // Loop-back compare: the transmitted word is held until its echo returns
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_hold_q <= '0;
         tx_pend_q <= 1'b0;
      end else if (TX_WORD_VALID) begin
         tx_hold_q <= TX_WORD;
         tx_pend_q <= 1'b1;
      end else if (LOOP_WORD_VALID) begin
         tx_pend_q <= 1'b0;
      end
   end

   // A mismatch in the strobe's own cycle still sets the flag
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         LOOPBACK_ERROR_OUT <= 1'b0;
      end else if (LOOP_WORD_VALID && tx_pend_q && LOOP_WORD != tx_hold_q) begin
         LOOPBACK_ERROR_OUT <= 1'b1;
      end else if (strobe_fall) begin
         LOOPBACK_ERROR_OUT <= 1'b0;
      end
   end

   hcs_pulse #(
      .LEN (hcs_pkg::STROBE_CYC)
   ) u_strobe (
      .clk     (CLK),
      .rst_b   (RST_B),
      .start   (valid_cmd),
      .abort   (1'b0),
      .pulse_n (strobe_n)
   );

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         strobe_prev_q    <= 1'b1;
         COMMAND_STROBE_N <= 1'b1;
      end else begin
         strobe_prev_q    <= strobe_n;
         COMMAND_STROBE_N <= strobe_n;
      end
   end

   assign strobe_fall = strobe_prev_q && !strobe_n;

   // Valid message: set before status transmit, cleared by next command word
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         VALID_MESSAGE <= 1'b0;
      end else if (CMD_EVT.cmd_word) begin
         VALID_MESSAGE <= 1'b0;
      end else if (SEQ_EVT.msg_done && !message_error_out_q) begin
         VALID_MESSAGE <= 1'b1;
      end
   end

   assign valid_message_rise = SEQ_EVT.msg_done && !message_error_out_q && !CMD_EVT.cmd_word && !VALID_MESSAGE;

   hcs_pulse #(
      .LEN (FAILSAFE_CYC)
   ) u_failsafe (
      .clk     (CLK),
      .rst_b   (RST_B),
      .start   (valid_message_rise),
      .abort   (!strobe_n),
      .pulse_n (fs_n)
   );

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         FAILSAFE_TIMER_N <= 1'b1;
      end else begin
         FAILSAFE_TIMER_N <= fs_n;
      end
   end

   // Command attributes latched on each valid command; terminal-to-terminal clears at message end or next command word
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         BROADCAST_N      <= 1'b1;
         TRANSMIT_RECEIVE <= 1'b0;
      end else if (valid_cmd) begin
         BROADCAST_N      <= !CMD_EVT.broadcast;
         TRANSMIT_RECEIVE <= CMD_EVT.transmit;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         TERMINAL_TO_TERMINAL <= 1'b0;
      end else if (valid_cmd) begin
         TERMINAL_TO_TERMINAL <= CMD_EVT.rt_to_rt;
      end else if (SEQ_EVT.msg_end || CMD_EVT.cmd_word) begin
         TERMINAL_TO_TERMINAL <= 1'b0;
      end
   end

   // Busy rises the selected lead time before the grant to the sequencer
   hcs_lead #(
      .SHORT_CYC (hcs_pkg::LEAD_SHORT_CYC),
      .LONG_CYC  (hcs_pkg::LEAD_LONG_CYC)
   ) u_lead (
      .clk         (CLK),
      .rst_b       (RST_B),
      .need        (SEQ_EVT.ram_need),
      .long_sel    (CONTROL_REG[hcs_pkg::CTRL_LEAD_BIT]),
      .release_ram (SEQ_EVT.ram_last),
      .busy        (lead_busy),
      .granted     (lead_grant)
   );

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         RAM_BUSY  <= 1'b0;
         RAM_GRANT <= 1'b0;
      end else begin
         RAM_BUSY  <= lead_busy && !SEQ_EVT.ram_last;
         RAM_GRANT <= lead_grant && !SEQ_EVT.ram_last;
      end
   end

   // Terminal active spans first to last RAM access of the command
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         active_q          <= 1'b0;
         TERMINAL_ACTIVE_N <= 1'b1;
      end else begin
         if (SEQ_EVT.ram_last)
            active_q <= 1'b0;
         else if (lead_grant)
            active_q <= 1'b1;
         TERMINAL_ACTIVE_N <= !(active_q && !SEQ_EVT.ram_last);
      end
   end

endmodule : hcs_top

// File: test/hcs_properties.sv
/*
 Checker for the host control/status pin block: event-to-pin timing.
 Assumes binding to hcs_top with its FAILSAFE_CYC handed on.
*/
`timescale 1ns/1ps
module hcs_properties #(
   parameter int FAILSAFE_CYC = 200
) (
   input wire logic              CLK,
   input wire logic              RST_B,
   input wire logic              CHIP_SELECT_N,
   input wire logic              OUTPUT_ENABLE_N,
   input wire logic              ILLEGAL_COMMAND_FLAG,
   input wire logic              DATA_OE,
   input wire hcs_pkg::hcs_cmd_s CMD_EVT,
   input wire hcs_pkg::hcs_seq_s SEQ_EVT,
   input wire logic              RAM_GRANT,
   input wire logic [15:0]       CONTROL_REG,
   input wire logic              MESSAGE_ERROR_OUT,
   input wire logic              FAILSAFE_TIMER_N,
   input wire logic              COMMAND_STROBE_N,
   input wire logic              TERMINAL_ACTIVE_N,
   input wire logic              VALID_MESSAGE,
   input wire logic              RAM_BUSY
);
   logic [7:0]  stb_q;
   logic [17:0] fs_q;
   logic        cut_q;
   logic [10:0] lead_q;
   wire         vcmd = CMD_EVT.cmd_valid && !ILLEGAL_COMMAND_FLAG;

   // Pulse lengths are counted in samples so a rising edge sees the full span
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         stb_q  <= 8'h00;
         fs_q   <= 18'h00000;
         cut_q  <= 1'b0;
         lead_q <= 11'h000;
      end else begin
         stb_q  <= COMMAND_STROBE_N ? 8'h00 : stb_q + 8'h01;
         fs_q   <= FAILSAFE_TIMER_N ? 18'h00000 : fs_q + 18'h00001;
         cut_q  <= !FAILSAFE_TIMER_N && (cut_q || vcmd);
         lead_q <= (RAM_BUSY && !RAM_GRANT) ? lead_q + 11'h001 : 11'h000;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   chk_oe_off: assert property (OUTPUT_ENABLE_N || CHIP_SELECT_N |=> !DATA_OE)
      else $error("data driven while off");
   chk_ctrl_hold: assert property (CHIP_SELECT_N |=> $stable(CONTROL_REG))
      else $error("control changed unselected");
   chk_strobe_go: assert property (vcmd |-> ##2 !COMMAND_STROBE_N)
      else $error("no command strobe");
   chk_strobe_len: assert property ($rose(COMMAND_STROBE_N) |-> stb_q == 8'h64)
      else $error("strobe length wrong");
   chk_illegal_cmd: assert property (CMD_EVT.cmd_valid && ILLEGAL_COMMAND_FLAG |->
      ##2 MESSAGE_ERROR_OUT && COMMAND_STROBE_N) else $error("illegal command accepted");
   chk_message_error_out_clear: assert property (vcmd && !SEQ_EVT.seq_error |-> ##2 !MESSAGE_ERROR_OUT)
      else $error("error not cleared");
   chk_valid_message_clear: assert property (CMD_EVT.cmd_word |=> !VALID_MESSAGE)
      else $error("valid message kept");
   chk_fs_len: assert property ($rose(FAILSAFE_TIMER_N) && !cut_q |-> fs_q == FAILSAFE_CYC)
      else $error("fail-safe length wrong");
   chk_fs_cut: assert property (vcmd && !FAILSAFE_TIMER_N |-> ##[1:4] FAILSAFE_TIMER_N)
      else $error("fail-safe not cut");
   chk_busy_go: assert property (SEQ_EVT.ram_need |-> ##2 RAM_BUSY)
      else $error("busy late");
   chk_lead_time: assert property ($rose(RAM_GRANT) |->
      lead_q == (CONTROL_REG[12] ? 11'h474 : 11'h21C)) else $error("lead time wrong");
   chk_active_busy: assert property (!TERMINAL_ACTIVE_N |-> RAM_BUSY && RAM_GRANT)
      else $error("active without busy");
   chk_ram_end: assert property (SEQ_EVT.ram_last |=> !RAM_BUSY && TERMINAL_ACTIVE_N)
      else $error("RAM use not ended");
endmodule : hcs_properties

bind hcs_top hcs_properties #(.FAILSAFE_CYC(FAILSAFE_CYC)) u_hcs_properties (
   .CLK, .RST_B, .CHIP_SELECT_N, .OUTPUT_ENABLE_N, .ILLEGAL_COMMAND_FLAG, .DATA_OE, .CMD_EVT,
   .SEQ_EVT, .RAM_GRANT, .CONTROL_REG, .MESSAGE_ERROR_OUT, .FAILSAFE_TIMER_N, .COMMAND_STROBE_N,
   .TERMINAL_ACTIVE_N, .VALID_MESSAGE, .RAM_BUSY
);

// File: test/hcs_ram_model.sv
/*
 Host-side shared RAM word: keeps what the host writes through the block.
 Assumes write strobe and data sampled on the core clock.
*/
`timescale 1ns/1ps
module hcs_ram_model (
   input  wire logic        clk,
   input  wire logic        we,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata = 16'hFFFF
);
   // One word only: the block carries no RAM address
   always @(posedge clk) begin
      if (we) begin
         rdata <= wdata;
      end
   end
endmodule : hcs_ram_model

// File: test/hcs_top_tb_top.sv
/*
 Testbench for hcs_top: drives host pins and events, judges status pins.
 Assumes the RAM model beside it and a shortened fail-safe count.
*/
`timescale 1ns/1ps
module hcs_top_tb_top;
   localparam int FS = 200;
   logic CLK = 1'b0, RST_B = 1'b0, ILLEGAL_COMMAND_FLAG = 1'b0, TX_WORD_VALID = 1'b0, LOOP_WORD_VALID = 1'b0;
   logic CHIP_SELECT_N = 1'b1, READ_WRITE = 1'b1, REG_ACCESS_N = 1'b1, OUTPUT_ENABLE_N = 1'b1;
   logic [15:0] DATA_IN = 16'h0000, TX_WORD = 16'h0000, LOOP_WORD = 16'h0000;
   hcs_pkg::hcs_cmd_s CMD_EVT = '0;
   hcs_pkg::hcs_seq_s SEQ_EVT = '0;
   logic [15:0] DATA_OUT, RAM_RDATA, CONTROL_REG;
   logic DATA_OE, RAM_HOST_WE, RAM_HOST_RE, RAM_GRANT, CMD_ILLEGAL, MESSAGE_ERROR_OUT, LOOPBACK_ERROR_OUT;
   logic FAILSAFE_TIMER_N, COMMAND_STROBE_N, TERMINAL_ACTIVE_N, BROADCAST_N, TRANSMIT_RECEIVE;
   logic TERMINAL_TO_TERMINAL, VALID_MESSAGE, RAM_BUSY;
   int num_errors = 0, checked = 0;

   hcs_top #(.FAILSAFE_CYC(FS)) u_hcs_top (.CLK, .RST_B, .CHIP_SELECT_N, .READ_WRITE, .REG_ACCESS_N,
      .OUTPUT_ENABLE_N, .ILLEGAL_COMMAND_FLAG, .DATA_IN, .DATA_OUT, .DATA_OE, .RAM_RDATA, .RAM_HOST_WE,
      .RAM_HOST_RE, .CMD_EVT, .SEQ_EVT, .RAM_GRANT, .TX_WORD_VALID, .TX_WORD, .LOOP_WORD_VALID, .LOOP_WORD,
      .CONTROL_REG, .CMD_ILLEGAL, .MESSAGE_ERROR_OUT, .LOOPBACK_ERROR_OUT, .FAILSAFE_TIMER_N,
      .COMMAND_STROBE_N, .TERMINAL_ACTIVE_N, .BROADCAST_N, .TRANSMIT_RECEIVE, .TERMINAL_TO_TERMINAL,
      .VALID_MESSAGE, .RAM_BUSY);
   hcs_ram_model u_hcs_ram_model (.clk(CLK), .we(RAM_HOST_WE), .wdata(DATA_IN), .rdata(RAM_RDATA));

   initial begin
      forever #2.5 CLK = ~CLK;
   end

   task automatic test_done();
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge CLK);
   endtask : cyc

   // p = {select_n, read, reg_n, oe_n}; held until the next call replaces it
   task automatic host(input logic [3:0] p, input logic [15:0] d);
      {CHIP_SELECT_N, READ_WRITE, REG_ACCESS_N, OUTPUT_ENABLE_N} = p;
      DATA_IN = d;
      cyc(1);
   endtask : host

   task automatic ev(input hcs_pkg::hcs_cmd_s c, input hcs_pkg::hcs_seq_s s, input logic ill);
      CMD_EVT = c;
      SEQ_EVT = s;
      ILLEGAL_COMMAND_FLAG = ill;
      cyc(1);
      CMD_EVT = '0;
      SEQ_EVT = '0;
      ILLEGAL_COMMAND_FLAG = 1'b0;
   endtask : ev

   task automatic lw(input logic [15:0] tx, input logic [15:0] lp);
      TX_WORD = tx;
      TX_WORD_VALID = 1'b1;
      cyc(1);
      TX_WORD_VALID = 1'b0;
      LOOP_WORD = lp;
      LOOP_WORD_VALID = 1'b1;
      cyc(1);
      LOOP_WORD_VALID = 1'b0;
   endtask : lw

   function automatic logic act(input int w);
      case (w)
         0: return !COMMAND_STROBE_N;
         1: return !FAILSAFE_TIMER_N;
         default: return RAM_BUSY && !RAM_GRANT;
      endcase
   endfunction : act

   // Counts settled cycles while the chosen indication is active
   task automatic span(input int w, input logic [15:0] exp);
      logic [15:0] n;
      n = 16'h0000;
      while (act(w) && n < 16'h1000) begin
         n++;
         cyc(1);
      end
      chk(n, exp);
   endtask : span

   task automatic t_host();
      host(4'b0001, 16'hA5A5);
      chk(CONTROL_REG, 16'hA5A5);
      host(4'b1001, 16'h5A5A);
      chk(CONTROL_REG, 16'hA5A5);
      host(4'b0011, 16'h1234);
      chk({CONTROL_REG[0], RAM_HOST_WE}, 2'b11);
      host(4'b0110, 16'h1234);
      host(4'b0110, 16'h1234);
      chk({DATA_OE, DATA_OUT}, 17'h11234);
      host(4'b0111, 16'h1234);
      chk(DATA_OE, 1'b0);
      host(4'b0100, 16'h1234);
      chk(DATA_OUT & 16'hFFF3, 16'h0000);
      host(4'b1111, 16'h1234);
   endtask : t_host

   task automatic t_cmd();
      ev(5'b11111, 5'h00, 1'b0);
      chk({BROADCAST_N, TRANSMIT_RECEIVE, TERMINAL_TO_TERMINAL}, 3'b011);
      cyc(1);
      span(0, 16'h0064);
      ev(5'h00, 5'b00100, 1'b0);
      chk({TRANSMIT_RECEIVE, TERMINAL_TO_TERMINAL}, 2'b10);
      ev(5'b11000, 5'h00, 1'b0);
      chk({BROADCAST_N, TRANSMIT_RECEIVE, TERMINAL_TO_TERMINAL}, 3'b100);
      cyc(1);
      span(0, 16'h0064);
   endtask : t_cmd

   task automatic t_err();
      ev(5'b11000, 5'h00, 1'b1);
      cyc(1);
      chk({MESSAGE_ERROR_OUT, COMMAND_STROBE_N, CMD_ILLEGAL}, 3'b111);
      ev(5'b11000, 5'h00, 1'b0);
      cyc(1);
      chk(MESSAGE_ERROR_OUT, 1'b0);
      span(0, 16'h0064);
      ev(5'h00, 5'b10000, 1'b0);
      cyc(1);
      chk(MESSAGE_ERROR_OUT, 1'b1);
      lw(16'h8001, 16'h8001);
      chk(LOOPBACK_ERROR_OUT, 1'b0);
      lw(16'h8001, 16'h8000);
      cyc(5);
      chk(LOOPBACK_ERROR_OUT, 1'b1);
      ev(5'b11000, 5'h00, 1'b0);
      cyc(1);
      span(0, 16'h0064);
      chk({LOOPBACK_ERROR_OUT, MESSAGE_ERROR_OUT}, 2'b00);
   endtask : t_err

   task automatic t_msg();
      ev(5'h00, 5'b01000, 1'b0);
      chk(VALID_MESSAGE, 1'b1);
      cyc(1);
      span(1, FS[15:0]);
      ev(5'b10000, 5'h00, 1'b0);
      chk(VALID_MESSAGE, 1'b0);
      ev(5'h00, 5'b01000, 1'b0);
      cyc(10);
      ev(5'b11000, 5'h00, 1'b0);
      cyc(3);
      chk(FAILSAFE_TIMER_N, 1'b1);
      cyc(100);
   endtask : t_msg

   task automatic t_ram(input logic [15:0] ctl, input logic [15:0] lead);
      host(4'b0001, ctl);
      host(4'b1111, ctl);
      ev(5'h00, 5'b00010, 1'b0);
      cyc(1);
      chk(RAM_BUSY, 1'b1);
      span(2, lead);
      cyc(1);
      chk({TERMINAL_ACTIVE_N, RAM_BUSY}, 2'b01);
      ev(5'h00, 5'b00001, 1'b0);
      chk({RAM_BUSY, TERMINAL_ACTIVE_N, RAM_GRANT}, 3'b010);
   endtask : t_ram

   initial begin
      cyc(10);
      RST_B = 1'b1;
      cyc(1);
      chk({FAILSAFE_TIMER_N, COMMAND_STROBE_N, TERMINAL_ACTIVE_N, VALID_MESSAGE, RAM_BUSY}, 5'h1C);
      t_host();
      t_cmd();
      t_err();
      t_msg();
      t_ram(16'h0000, 16'h021C);
      t_ram(16'h1000, 16'h0474);
      test_done();
   end

   initial begin
      #100000;
      num_errors++;
      test_done();
   end
endmodule : hcs_top_tb_top
